/* logic/bbps_params.svh */
// Offsets, field positions, reset values and timing counts of the phase sequencer
`ifndef BBPS_PARAMS_SVH
`define BBPS_PARAMS_SVH
`define BBPS_ADDR_MODE 8'h55
`define BBPS_ADDR_PEAK 8'h57
`define BBPS_ADDR_CFG2 8'h58
`define BBPS_ADDR_CFG1 8'h56
`define BBPS_MODE_BIT 1
`define BBPS_LOOKUP_DIS_BIT 2
`define BBPS_ADAPT_DIS_BIT 3
`define BBPS_ZC_DIS_BIT 4
`define BBPS_FTHR_LSB 0
`define BBPS_FTHR_MSB 3
`define BBPS_RST_MODE 8'h00
`define BBPS_RST_PEAK 8'h00
`define BBPS_RST_CFG2 8'h00
`define BBPS_RST_CFG1 8'h00
`define BBPS_CLK_PERIOD_PS 4000
`define BBPS_TIMEOUT_NS 500
`define BBPS_TIMEOUT_CYC ((`BBPS_TIMEOUT_NS * 1000) / `BBPS_CLK_PERIOD_PS)
`define BBPS_FREEWHEEL_NS 30
`define BBPS_FREEWHEEL_CYC ((`BBPS_FREEWHEEL_NS * 1000 + `BBPS_CLK_PERIOD_PS - 1) / `BBPS_CLK_PERIOD_PS)
`define BBPS_LUT_DEPTH 16
`endif

/* logic/bbps_pkg.sv */
// Types of the phase sequencer
`default_nettype none
package bbps_pkg;
    typedef enum logic [2:0] {
        BBPS_IDLE = 3'b000,
        BBPS_PH1 = 3'b001,
        BBPS_PH2 = 3'b010,
        BBPS_PH3 = 3'b011,
        BBPS_PH4 = 3'b100
    } bbps_phase_t;
endpackage
`default_nettype wire

/* logic/bbps_lut.sv */
// Peak setting lookup table indexed by output voltage setting
`timescale 1ns/1ps
`default_nettype none
module bbps_lut #(
    parameter int DEPTH = 16
) (
    input wire logic clk,
    input wire logic [3:0] addr,
    output logic [7:0] rdata
);
    logic [7:0] rdata_r;
    logic [7:0] rom_val;
    // ----------------------------------------
    // Table: low nibble primary, high nibble secondary
    // ----------------------------------------
    always_comb begin
        rom_val = {addr, 4'(addr + 4'h4)};
    end
    always_ff @(posedge clk) begin
        rdata_r <= rom_val;
    end
    assign rdata = rdata_r;
endmodule
`default_nettype wire

/* logic/bbps_seq.sv */
// Buck-boost switching phase sequencer with configuration registers
`timescale 1ns/1ps
`default_nettype none
`include "bbps_params.svh"
module bbps_seq #(
    parameter int TIMEOUT_CYC = `BBPS_TIMEOUT_CYC,
    parameter int FREEWHEEL_CYC = `BBPS_FREEWHEEL_CYC
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    input wire logic [3:0] output_voltage_setting,
    input wire logic start_cycle,
    input wire logic ccm_mode,
    input wire logic cmp_peak,
    input wire logic cmp_valley,
    input wire logic cmp_zero,
    input wire logic cmp_vin_gt_vout,
    input wire logic [5:0] freq_level,
    output logic input_high_side_switch,
    output logic input_low_side_switch,
    output logic output_high_side_switch,
    output logic output_low_side_switch,
    output logic [3:0] peak_target,
    output logic valley_zero,
    output logic adaptive_enable,
    output logic low_iq_mode
);
    typedef struct packed {
        logic [7:0] mode_r;
        logic [7:0] peak_r;
        logic [7:0] cfg1_r;
        logic [7:0] cfg2_r;
        logic [7:0] rdata_r;
        logic [1:0] pk_s;
        logic [1:0] va_s;
        logic [1:0] zc_s;
        logic [1:0] vg_s;
        logic [11:0] fq_s;
        bbps_pkg::bbps_phase_t ph_r;
        logic [9:0] cnt_r;
        logic [3:0] sw_r;
        logic [3:0] tgt_r;
        logic vz_r;
        logic ad_r;
        logic liq_r;
    } bbps_state_t;

    bbps_state_t st_r;
    bbps_state_t st_nxt;
    logic [7:0] lut_data;
    logic [3:0] prim;
    logic [3:0] sec;
    logic [4:0] sum;
    logic [3:0] thr;
    logic [5:0] f_now;
    logic pk;
    logic va;
    logic zc;
    logic vg;
    logic buck_only;
    logic zc_dis;
    logic tmo;
    logic dis_end;
    logic pk_ok;

    bbps_lut #(.DEPTH(`BBPS_LUT_DEPTH)) u_lut (
        .clk(clk),
        .addr(output_voltage_setting),
        .rdata(lut_data)
    );

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb begin
        st_nxt = st_r;
        // Two-flop synchronisers, second stage only is used
        st_nxt.pk_s = {st_r.pk_s[0], cmp_peak};
        st_nxt.va_s = {st_r.va_s[0], cmp_valley};
        st_nxt.zc_s = {st_r.zc_s[0], cmp_zero};
        st_nxt.vg_s = {st_r.vg_s[0], cmp_vin_gt_vout};
        st_nxt.fq_s = {st_r.fq_s[5:0], freq_level};
        pk = st_r.pk_s[1];
        va = st_r.va_s[1];
        zc = st_r.zc_s[1];
        vg = st_r.vg_s[1];
        f_now = st_r.fq_s[11:6];
        buck_only = st_r.mode_r[`BBPS_MODE_BIT];
        zc_dis = st_r.cfg2_r[`BBPS_ZC_DIS_BIT];
        // Peak source
        if (st_r.cfg2_r[`BBPS_LOOKUP_DIS_BIT]) begin
            prim = st_r.peak_r[3:0];
            sec = st_r.peak_r[7:4];
        end else begin
            prim = lut_data[3:0];
            sec = lut_data[7:4];
        end
        sum = 5'(prim) + 5'(sec);
        if (buck_only || !vg || st_r.ph_r == bbps_pkg::BBPS_PH2) begin
            st_nxt.tgt_r = prim;
        end else begin
            st_nxt.tgt_r = (sum > 5'h0f) ? 4'hf : sum[3:0];
        end
        st_nxt.ad_r = !st_r.cfg2_r[`BBPS_ADAPT_DIS_BIT];
        st_nxt.vz_r = st_r.cfg2_r[`BBPS_ADAPT_DIS_BIT] || (zc_dis && !ccm_mode);
        // Discharge end: DCM via zero cross or valley unless disabled, CCM via valley
        if (zc_dis) begin
            dis_end = va;
        end else begin
            dis_end = ccm_mode ? va : (zc || va);
        end
        tmo = (st_r.cnt_r == 10'h000);
        // Peak compare stale until the new phase 1 target has passed target register and synchroniser
        pk_ok = (st_r.cnt_r <= 10'(TIMEOUT_CYC - 4));
        // Frequency hysteresis
        thr = st_r.cfg1_r[`BBPS_FTHR_MSB:`BBPS_FTHR_LSB];
        if (f_now >= {thr, 2'b00}) begin
            st_nxt.liq_r = 1'b0;
        end else if (f_now <= {2'b00, thr}) begin
            st_nxt.liq_r = 1'b1;
        end
        // Phase machine
        case (st_r.ph_r)
            bbps_pkg::BBPS_IDLE: begin
                if (start_cycle) begin
                    if (buck_only) begin
                        st_nxt.ph_r = bbps_pkg::BBPS_PH1;
                        st_nxt.cnt_r = 10'(TIMEOUT_CYC - 1);
                    end else begin
                        st_nxt.ph_r = bbps_pkg::BBPS_PH2;
                    end
                end
            end
            bbps_pkg::BBPS_PH2: begin
                if (pk) begin
                    st_nxt.ph_r = bbps_pkg::BBPS_PH1;
                    st_nxt.cnt_r = 10'(TIMEOUT_CYC - 1);
                end
            end
            bbps_pkg::BBPS_PH1: begin
                if (!tmo) begin
                    st_nxt.cnt_r = st_r.cnt_r - 10'h001;
                end
                if (buck_only) begin
                    if (pk) begin
                        st_nxt.ph_r = bbps_pkg::BBPS_PH3;
                        st_nxt.cnt_r = 10'h000;
                    end
                end else if ((vg && ((pk && pk_ok) || tmo)) || (!vg && (tmo || dis_end))) begin
                    st_nxt.ph_r = bbps_pkg::BBPS_PH3;
                    st_nxt.cnt_r = 10'h000;
                end
            end
            bbps_pkg::BBPS_PH3: begin
                if (dis_end) begin
                    if (ccm_mode && !zc_dis) begin
                        st_nxt.ph_r = bbps_pkg::BBPS_IDLE;
                    end else begin
                        st_nxt.ph_r = bbps_pkg::BBPS_PH4;
                        st_nxt.cnt_r = 10'(FREEWHEEL_CYC - 1);
                    end
                end
            end
            bbps_pkg::BBPS_PH4: begin
                if (ccm_mode) begin
                    if (tmo) begin
                        st_nxt.ph_r = bbps_pkg::BBPS_IDLE;
                    end else begin
                        st_nxt.cnt_r = st_r.cnt_r - 10'h001;
                    end
                end else if (start_cycle) begin
                    st_nxt.ph_r = buck_only ? bbps_pkg::BBPS_PH1 : bbps_pkg::BBPS_PH2;
                    st_nxt.cnt_r = 10'(TIMEOUT_CYC - 1);
                end
            end
            default: begin
                st_nxt.ph_r = bbps_pkg::BBPS_IDLE;
            end
        endcase
        // Switch encoding: {in_hi, in_lo, out_hi, out_lo}
        case (st_nxt.ph_r)
            bbps_pkg::BBPS_PH1: st_nxt.sw_r = 4'b1010;
            bbps_pkg::BBPS_PH2: st_nxt.sw_r = 4'b1001;
            bbps_pkg::BBPS_PH3: st_nxt.sw_r = 4'b0110;
            bbps_pkg::BBPS_PH4: st_nxt.sw_r = 4'b0101;
            default: st_nxt.sw_r = 4'b0000;
        endcase
        // Registers
        if (reg_wr) begin
            case (reg_addr)
                `BBPS_ADDR_MODE: st_nxt.mode_r = reg_wdata;
                `BBPS_ADDR_PEAK: st_nxt.peak_r = reg_wdata;
                `BBPS_ADDR_CFG1: st_nxt.cfg1_r = reg_wdata;
                `BBPS_ADDR_CFG2: st_nxt.cfg2_r = reg_wdata;
                default: ;
            endcase
        end
        if (reg_rd) begin
            case (reg_addr)
                `BBPS_ADDR_MODE: st_nxt.rdata_r = st_r.mode_r;
                `BBPS_ADDR_PEAK: st_nxt.rdata_r = st_r.peak_r;
                `BBPS_ADDR_CFG1: st_nxt.rdata_r = st_r.cfg1_r;
                `BBPS_ADDR_CFG2: st_nxt.rdata_r = st_r.cfg2_r;
                default: st_nxt.rdata_r = 8'h00;
            endcase
        end
    end

    // ----------------------------------------
    // State register
    // ----------------------------------------
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st_r <= '0;
            st_r.mode_r <= `BBPS_RST_MODE;
            st_r.peak_r <= `BBPS_RST_PEAK;
            st_r.cfg1_r <= `BBPS_RST_CFG1;
            st_r.cfg2_r <= `BBPS_RST_CFG2;
            st_r.ph_r <= bbps_pkg::BBPS_IDLE;
            st_r.liq_r <= 1'b1;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign reg_rdata = st_r.rdata_r;
    assign input_high_side_switch = st_r.sw_r[3];
    assign input_low_side_switch = st_r.sw_r[2];
    assign output_high_side_switch = st_r.sw_r[1];
    assign output_low_side_switch = st_r.sw_r[0];
    assign peak_target = st_r.tgt_r;
    assign valley_zero = st_r.vz_r;
    assign adaptive_enable = st_r.ad_r;
    assign low_iq_mode = st_r.liq_r;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    AST_TWO_MAX: assert property (@(posedge clk) disable iff (!rst_n) $countones(st_r.sw_r) <= 2)
        else $error("More than two switches on");
    AST_NO_SHOOT: assert property (@(posedge clk) disable iff (!rst_n)
        !(input_high_side_switch && input_low_side_switch) && !(output_high_side_switch && output_low_side_switch))
        else $error("Leg shoot-through");
    AST_BB_START: assert property (@(posedge clk) disable iff (!rst_n)
        (st_r.ph_r == bbps_pkg::BBPS_IDLE && start_cycle && !buck_only) |=> st_r.ph_r == bbps_pkg::BBPS_PH2)
        else $error("Buck-boost did not start in phase 2");
    AST_BUCK_NO_P2: assert property (@(posedge clk) disable iff (!rst_n)
        (buck_only && $stable(buck_only)) |-> st_r.ph_r != bbps_pkg::BBPS_PH2 || $past(st_r.ph_r) == bbps_pkg::BBPS_PH2)
        else $error("Phase 2 entered in buck-only mode");
    AST_P2_TO_P1: assert property (@(posedge clk) disable iff (!rst_n)
        (st_r.ph_r == bbps_pkg::BBPS_PH2 && pk) |=> st_r.ph_r == bbps_pkg::BBPS_PH1)
        else $error("Phase 2 did not end at peak");
    AST_P1_TMO: assert property (@(posedge clk) disable iff (!rst_n)
        ($rose(st_r.ph_r == bbps_pkg::BBPS_PH1) && !buck_only) |-> ##[0:130] st_r.ph_r != bbps_pkg::BBPS_PH1)
        else $error("Phase 1 outlasted timeout");
    AST_P1_LOAD: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(st_r.ph_r == bbps_pkg::BBPS_PH1) |-> st_r.cnt_r == 10'(TIMEOUT_CYC - 1))
        else $error("Timeout counter not loaded");
    AST_CCM_SKIP: assert property (@(posedge clk) disable iff (!rst_n)
        (st_r.ph_r == bbps_pkg::BBPS_PH3 && ccm_mode && !zc_dis && dis_end) |=> st_r.ph_r == bbps_pkg::BBPS_IDLE)
        else $error("Phase 4 not skipped in CCM");
    AST_LIQ_OFF: assert property (@(posedge clk) disable iff (!rst_n)
        (f_now >= {thr, 2'b00}) |=> !low_iq_mode)
        else $error("Low-iq mode not left at threshold");
    AST_LOOKUP: assert property (@(posedge clk) disable iff (!rst_n)
        (!st_r.cfg2_r[`BBPS_LOOKUP_DIS_BIT] && buck_only) |=> peak_target == $past(lut_data[3:0]))
        else $error("Lookup peak not applied");
    COV_P4: cover property (@(posedge clk) st_r.ph_r == bbps_pkg::BBPS_PH4);
    COV_BUCK: cover property (@(posedge clk) buck_only && st_r.ph_r == bbps_pkg::BBPS_PH3);
    COV_TMO: cover property (@(posedge clk) st_r.ph_r == bbps_pkg::BBPS_PH1 && tmo);
endmodule
`default_nettype wire

/* sim/bbps_plant.sv */
// Inductor current and comparator model for the phase sequencer
`timescale 1ns/1ps
`default_nettype none
module bbps_plant (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [3:0] sw,
    input wire logic [3:0] peak_target,
    input wire logic valley_zero,
    input wire logic vin_gt_vout,
    input wire logic ccm,
    output logic cmp_peak,
    output logic cmp_valley,
    output logic cmp_zero
);
    logic [9:0] cur_r;
    // ----------------------------------------
    // Current slope follows the switch pair
    // ----------------------------------------
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cur_r <= 10'h000;
        end else begin
            case (sw)
                4'h9: cur_r <= cur_r + 10'h002;
                4'ha: cur_r <= cur_r + {9'h000, vin_gt_vout};
                4'h6: cur_r <= (cur_r == 10'h000) ? cur_r : cur_r - 10'h001;
                4'h5: cur_r <= cur_r;
                default: cur_r <= ccm ? cur_r : 10'h000;
            endcase
        end
    end
    assign cmp_peak = cur_r >= {4'h0, peak_target, 2'b00};
    assign cmp_valley = cur_r <= (valley_zero ? 10'h000 : 10'h002);
    assign cmp_zero = cur_r == 10'h000;
endmodule
`default_nettype wire

/* sim/tb_top.sv */
// Self-checking testbench of the phase sequencer
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    localparam int TO = 20;
    localparam int FW = 4;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic [7:0] reg_rdata;
    logic start_cycle = 1'b0;
    logic ccm = 1'b0;
    logic vin = 1'b0;
    logic [5:0] freq_level = 6'h00;
    logic [3:0] vset = 4'h5;
    logic cp, cv, cz, ih, il, oh, ol, valley_zero, adaptive_enable, low_iq_mode;
    logic [3:0] peak_target;
    logic [3:0] sw;
    logic [3:0] obs [4];
    int olen [4];
    int nobs;
    int bad_count = 0;
    int tests_run = 0;
    assign sw = {ih, il, oh, ol};
    always #2 clk = ~clk;
    bbps_seq #(.TIMEOUT_CYC(TO), .FREEWHEEL_CYC(FW)) i_bbps_seq (.clk(clk), .rst_n(rst_n), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .output_voltage_setting(vset), .start_cycle(start_cycle), .ccm_mode(ccm), .cmp_peak(cp), .cmp_valley(cv),
        .cmp_zero(cz), .cmp_vin_gt_vout(vin), .freq_level(freq_level), .input_high_side_switch(ih),
        .input_low_side_switch(il), .output_high_side_switch(oh), .output_low_side_switch(ol),
        .peak_target(peak_target), .valley_zero(valley_zero), .adaptive_enable(adaptive_enable),
        .low_iq_mode(low_iq_mode));
    bbps_plant i_bbps_plant (.clk(clk), .rst_n(rst_n), .sw(sw), .peak_target(peak_target),
        .valley_zero(valley_zero), .vin_gt_vout(vin), .ccm(ccm), .cmp_peak(cp), .cmp_valley(cv), .cmp_zero(cz));
    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic summarize();
        $display("checks %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            bad_count++;
            $display("unexpected %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic wait_cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic do_reset();
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        wait_cyc(1);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
    endtask
    task automatic cfg(input logic mode, input logic zcdis);
        wr(8'h55, {6'h00, mode, 1'b0});
        wr(8'h57, 8'h53);
        wr(8'h58, {3'h0, zcdis, 4'hc});
    endtask
    task automatic record();
        logic [3:0] p;
        nobs = 0;
        obs = '{default: 4'h0};
        olen = '{default: 0};
        @(posedge clk);
        start_cycle <= 1'b1;
        @(posedge clk);
        start_cycle <= 1'b0;
        for (int i = 0; i < 400; i++) begin
            wait_cyc(1);
            p = sw;
            check("switches_on", $countones(p) > 2, 1'b0);
            if (p == 4'h0 && nobs > 0) break;
            if (p != 4'h0 && (nobs == 0 || (nobs <= 4 && p !== obs[nobs - 1]))) begin
                if (nobs < 4) obs[nobs] = p;
                if (nobs < 4) olen[nobs] = 1;
                nobs++;
            end else if (p != 4'h0 && nobs <= 4) begin
                olen[nobs - 1]++;
            end
        end
    endtask
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_reset();
        logic [7:0] d;
        @(posedge clk);
        #1;
        check("low_iq_rst", low_iq_mode, 1'b1);
        do_reset();
        check("switches", sw, 4'h0);
        // Zero threshold field: frequency already at the high threshold
        check("low_iq", low_iq_mode, 1'b0);
        for (int a = 8'h55; a <= 8'h58; a++) begin
            rd(a[7:0], d);
            check("reg_reset", d, 8'h00);
        end
        wr(8'h57, 8'ha5);
        rd(8'h57, d);
        check("peak_reg", d, 8'ha5);
        wr(8'h40, 8'hff);
        rd(8'h40, d);
        check("unmapped", d, 8'h00);
        $display("t_reset done");
    endtask
    task automatic t_peak();
        logic [3:0] t;
        cfg(1'b0, 1'b1);
        vin <= 1'b0;
        wait_cyc(6);
        check("peak_low_vin", peak_target, 4'h3);
        check("valley_zero", valley_zero, 1'b1);
        check("adaptive", adaptive_enable, 1'b0);
        @(posedge clk);
        vin <= 1'b1;
        wait_cyc(6);
        check("peak_sum", peak_target, 4'h8);
        wr(8'h55, 8'h02);
        wait_cyc(6);
        check("peak_buck", peak_target, 4'h3);
        wr(8'h58, 8'h00);
        wait_cyc(3);
        check("adaptive_on", adaptive_enable, 1'b1);
        t = peak_target;
        wr(8'h57, 8'h11);
        wait_cyc(4);
        check("peak_field_ignored", peak_target, t);
        @(posedge clk);
        vset <= 4'h9;
        wait_cyc(4);
        check("peak_tracks_vset", peak_target != t, 1'b1);
        $display("t_peak done");
    endtask
    task automatic t_seq(input logic mode, input logic zcdis, input logic c, input logic v);
        do_reset();
        @(posedge clk);
        ccm <= c;
        vin <= v;
        cfg(mode, zcdis);
        wait_cyc(4);
        record();
    endtask
    task automatic t_bb_dcm();
        logic [3:0] e [4] = '{4'h9, 4'ha, 4'h6, 4'h5};
        t_seq(1'b0, 1'b1, 1'b0, 1'b1);
        for (int i = 0; i < 4; i++) check("bb_phase", obs[i], e[i]);
        check("bb_ph1_held", olen[1] > 4, 1'b1);
        $display("t_bb_dcm done");
    endtask
    task automatic t_timeout();
        t_seq(1'b0, 1'b1, 1'b0, 1'b0);
        check("ph1_pattern", obs[1], 4'ha);
        check("ph1_length", olen[1], TO);
        $display("t_timeout done");
    endtask
    task automatic t_buck();
        t_seq(1'b1, 1'b1, 1'b0, 1'b1);
        check("buck_charge", obs[0], 4'ha);
        check("buck_transfer", obs[1], 4'h6);
        $display("t_buck done");
    endtask
    task automatic t_ccm();
        t_seq(1'b0, 1'b1, 1'b1, 1'b1);
        check("ccm_fw", obs[3], 4'h5);
        check("ccm_fw_len", olen[3], FW);
        t_seq(1'b0, 1'b0, 1'b1, 1'b1);
        check("ccm_count", nobs, 3);
        check("ccm_last", obs[2], 4'h6);
        @(posedge clk);
        ccm <= 1'b0;
        $display("t_ccm done");
    endtask
    task automatic t_lowiq();
        logic [5:0] f [4] = '{6'h0f, 6'h10, 6'h05, 6'h04};
        logic e [4] = '{1'b1, 1'b0, 1'b0, 1'b1};
        do_reset();
        wr(8'h56, 8'h04);
        for (int i = 0; i < 4; i++) begin
            @(posedge clk);
            freq_level <= f[i];
            wait_cyc(6);
            check("low_iq", low_iq_mode, e[i]);
        end
        $display("t_lowiq done");
    endtask
    initial begin
        t_reset();
        t_peak();
        t_bb_dcm();
        t_timeout();
        t_buck();
        t_ccm();
        t_lowiq();
        summarize();
    end
    initial begin
        repeat (60000) @(posedge clk);
        bad_count++;
        summarize();
    end
endmodule
`default_nettype wire
